//--- design/pnlio_regs.v
// Panel I/O register bank: revision, status, control, tone, keypad, DAC
`timescale 1ns/1ns
`include "pnlio_defs.vh"
// Operation
// R1: Speaker output carries a 4 kHz square wave while a tone is active.
// R2: A 16-bit write to the tone register starts the tone.
// R3: Bit 15 set keeps the tone on continuously, never timing out.
// R4: Tone register writes are always accepted, even mid-tone.
// R5: A larger value written mid-tone lengthens the tone.
// R6: A smaller value written mid-tone shortens the tone.
// R7: Keypad register shows high row and column lines of pressed keys.
// R8: Several pressed keys show as the OR of their patterns.
// R9: A 16-bit register returns the logic revision.
// R10: Status register is read only; writes do not change it.
// R11: Control register is write only; reads do not return it.
// R12: Display settings are shifted into the serial DAC as 16 bits.
// R13: Host puts channel 11 for contrast, 12 for backlight into the word.
// R14: Configuration comes from the host or a local serial PROM. Here only host writes set it; there is no PROM port.
// R15: Host-side logic steers the data bus buffer enable and direction. This block drives no buffer enable or direction pin.
// R16: Low fifteen bits count down in milliseconds; zero silences speaker.
module pnlio_regs #(
   parameter KEY_W    = 16,
   parameter REV_CODE = `PNLIO_REV_VAL   // Arbitrary revision value
) (
   // Clock and reset
   input wire              MCLK,
   input wire              RESETN,
   // Processor bus
   input wire              CS,
   input wire              WR,
   input wire              RD,
   input wire [2:0]        ADDR,
   input wire [15:0]       WDATA,
   output reg [15:0]       RDATA,
   // Keypad lines
   input wire [KEY_W-1:0]  KEYS,
   // Speaker
   output reg              SPEAKER,
   // Control register outputs
   output reg [15:0]       CTRL_OUT,
   // Shared audio serial bus to the DAC
   output reg              SHARED_AUDIO_SERIAL_BUS_SCLK,
   output reg              SHARED_AUDIO_SERIAL_BUS_SDAT,
   output reg              SHARED_AUDIO_SERIAL_BUS_SYNC_N
);
   // Cycle counts derived from the clock rate
   localparam integer HALF_TONE = `PNLIO_CLK_HZ / (2 * `PNLIO_TONE_HZ);
   localparam integer MS_CNT    = `PNLIO_CLK_HZ / `PNLIO_TICK_HZ;

   // Tone state machine
   localparam ST_IDLE = 2'b00;
   localparam ST_TIME = 2'b01;
   localparam ST_CONT = 2'b10;

   // Tone timing state
   reg [1:0]        st_q;
   reg [14:0]       dur_q;
   reg [15:0]       half_q;
   reg [15:0]       ms_q;
   reg              sq_q;

   // Keypad sample and DAC word capture
   reg [KEY_W-1:0]  keys_q;
   reg              dac_ld_q;
   reg [15:0]       dac_w_q;

   // Serial shifter outputs
   wire             dac_busy;
   wire             dac_sclk;
   wire             dac_sdat;
   wire             dac_sync_n;

   // Decoded strobes and status
   wire             wr_tone;
   wire             wr_ctrl;
   wire             wr_dac;
   wire             ms_tick;
   wire             tone_on;
   wire             tone_cont;
   wire [15:0]      stat_w;

   // Next values of the registers above
   reg [1:0]        st_d;
   reg [14:0]       dur_d;
   reg [15:0]       half_d;
   reg [15:0]       ms_d;
   reg              sq_d;
   reg              spk_d;
   reg [KEY_W-1:0]  keys_d;
   reg              dac_ld_d;
   reg [15:0]       dac_w_d;
   reg [15:0]       ctrl_d;
   reg [15:0]       rdata_d;

   // Write strobe decode
   function is_wr;
      input [2:0] a;
      input [2:0] ofs;
      begin
         is_wr = CS && WR && (a == ofs);
      end
   endfunction

   // Register write strobes
   assign wr_tone = is_wr(ADDR, `PNLIO_OFS_TONE);
   assign wr_ctrl = is_wr(ADDR, `PNLIO_OFS_CTRL);
   assign wr_dac  = is_wr(ADDR, `PNLIO_OFS_DAC);

   // Last cycle of each millisecond of tone time
   assign ms_tick = (ms_q == MS_CNT - 1);

   // Tone state as seen by the host and the speaker pin
   assign tone_on   = (st_q != ST_IDLE);
   assign tone_cont = (st_q == ST_CONT);

   // Status bits: tone state and DAC shifter busy
   assign stat_w = {13'h0000, dac_busy, tone_cont, tone_on};

   // Tone next state; a write always reloads the duration
   always @* begin
      st_d  = st_q;
      dur_d = dur_q;
      if (wr_tone) begin                                // R4
         dur_d = WDATA[`PNLIO_TONE_MSB:0];              // R5 R6
         if (WDATA[`PNLIO_TONE_CONT])
            st_d = ST_CONT;                             // R3
         else if (WDATA[`PNLIO_TONE_MSB:0] != 15'h0000)
            st_d = ST_TIME;                             // R2
         else
            st_d = ST_IDLE;
      end else begin
         case (st_q)
            ST_TIME: begin
               if (ms_tick) begin
                  if (dur_q == 15'h0001)
                     st_d = ST_IDLE;                    // R16
                  dur_d = dur_q - 15'h0001;             // R16
               end
            end
            ST_CONT: st_d = ST_CONT;
            ST_IDLE: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // Tone state registers
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         st_q  <= ST_IDLE;
         dur_q <= 15'h0000;
      end else begin
         st_q  <= st_d;
         dur_q <= dur_d;
      end
   end

   // Millisecond divider next value, restarted by each tone write
   always @* begin
      if (wr_tone || ms_tick || st_q != ST_TIME)
         ms_d = 16'h0000;
      else
         ms_d = ms_q + 16'h0001;
   end

   // Millisecond divider register
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         ms_q <= 16'h0000;
      else
         ms_q <= ms_d;
   end

   // 4 kHz square wave next state, parked low while idle
   always @* begin
      half_d = half_q + 16'h0001;
      sq_d   = sq_q;
      if (!tone_on) begin
         half_d = 16'h0000;
         sq_d   = 1'b0;
      end else if (half_q == HALF_TONE - 1) begin
         half_d = 16'h0000;
         sq_d   = ~sq_q;                                // R1
      end
   end

   // Square wave registers
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         half_q <= 16'h0000;
         sq_q   <= 1'b0;
      end else begin
         half_q <= half_d;
         sq_q   <= sq_d;
      end
   end

   // Speaker level, silent when idle
   always @* begin
      spk_d = sq_q && tone_on;                          // R1
   end

   // Speaker pin from a flop
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         SPEAKER <= 1'b0;
      else
         SPEAKER <= spk_d;
   end

   // Keypad lines already carry the OR of all pressed keys
   always @* begin
      keys_d = KEYS;                                    // R7 R8
   end

   // Keypad sample register
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         keys_q <= {KEY_W{1'b0}};
      else
         keys_q <= keys_d;
   end

   // Write-only control register next value
   always @* begin
      ctrl_d = CTRL_OUT;
      if (wr_ctrl)
         ctrl_d = WDATA;                                // R11
   end

   // Control register, driven straight to its pins
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         CTRL_OUT <= `PNLIO_CTRL_RST;
      else
         CTRL_OUT <= ctrl_d;
   end

   // DAC word capture; a write while busy is held until the shifter frees
   always @* begin
      dac_ld_d = dac_ld_q;
      dac_w_d  = dac_w_q;
      if (wr_dac) begin
         dac_ld_d = 1'b1;
         dac_w_d  = WDATA;                              // R13
      end else if (!dac_busy) begin
         dac_ld_d = 1'b0;
      end
   end

   // DAC load request and word registers
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         dac_ld_q <= 1'b0;
         dac_w_q  <= 16'h0000;
      end else begin
         dac_ld_q <= dac_ld_d;
         dac_w_q  <= dac_w_d;
      end
   end

   // Read mux; the status register ignores writes, control reads zero
   always @* begin
      rdata_d = RDATA;
      if (CS && RD) begin
         case (ADDR)
            `PNLIO_OFS_REV:  rdata_d = REV_CODE[15:0];  // R9
            `PNLIO_OFS_STAT: rdata_d = stat_w;          // R10
            `PNLIO_OFS_KEYS: rdata_d = keys_q;          // R7
            default:         rdata_d = 16'h0000;        // R11
         endcase
      end
   end

   // Read data register, held until the next read
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         RDATA <= 16'h0000;
      else
         RDATA <= rdata_d;
   end

   // Serial DAC loader
   pnlio_dac_shift u_dac (
      .clk    (MCLK),
      .rst_n  (RESETN),
      .load   (dac_ld_q),
      .word   (dac_w_q),
      .busy   (dac_busy),
      .sclk   (dac_sclk),
      .sdat   (dac_sdat),
      .sync_n (dac_sync_n)
   );

   // Serial pins retimed through output flops
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         SHARED_AUDIO_SERIAL_BUS_SCLK   <= 1'b0;
         SHARED_AUDIO_SERIAL_BUS_SDAT   <= 1'b0;
         SHARED_AUDIO_SERIAL_BUS_SYNC_N <= 1'b1;
      end else begin
         SHARED_AUDIO_SERIAL_BUS_SCLK   <= dac_sclk;    // R12
         SHARED_AUDIO_SERIAL_BUS_SDAT   <= dac_sdat;
         SHARED_AUDIO_SERIAL_BUS_SYNC_N <= dac_sync_n;
      end
   end
endmodule

//--- design/pnlio_defs.vh
// Constants of the panel I/O register bank
`ifndef PNLIO_DEFS_VH
`define PNLIO_DEFS_VH
// Register word offsets on the local bus
`define PNLIO_OFS_REV    3'h0
`define PNLIO_OFS_STAT   3'h1
`define PNLIO_OFS_CTRL   3'h2
`define PNLIO_OFS_TONE   3'h3
`define PNLIO_OFS_KEYS   3'h4
`define PNLIO_OFS_DAC    3'h5
// Field layout of the tone duration register
`define PNLIO_TONE_CONT  15
`define PNLIO_TONE_MSB   14
// Timing
`define PNLIO_CLK_HZ     10000000
`define PNLIO_TONE_HZ    4000
`define PNLIO_TICK_HZ    1000
`define PNLIO_SCLK_DIV   8'h04
// Control reset value, revision code and DAC frame bit count
`define PNLIO_CTRL_RST   16'h0000
`define PNLIO_REV_VAL    16'h0101
`define PNLIO_DAC_BITS   5'h10
`endif

//--- design/pnlio_dac_shift.v
// Serial shifter that loads a 16-bit word into the display DAC
`timescale 1ns/1ns
`include "pnlio_defs.vh"
module pnlio_dac_shift (
   // Clock and reset
   input wire        clk,
   input wire        rst_n,
   // Load request
   input wire        load,
   input wire [15:0] word,
   output reg        busy,
   // Serial lines
   output reg        sclk,
   output reg        sdat,
   output reg        sync_n
);
   reg [15:0] sh_q;
   reg [4:0]  cnt_q;
   reg [7:0]  div_q;
   wire       tick;

   // Half-bit enable pulse from the divider
   assign tick = (div_q == `PNLIO_SCLK_DIV);

   // Divider runs only while shifting
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         div_q <= 8'h00;
      else if (!busy || tick)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end

   // Shift MSB first, data changes on the falling edge of sclk
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q   <= 16'h0000;
         cnt_q  <= 5'h00;
         busy   <= 1'b0;
         sclk   <= 1'b0;
         sdat   <= 1'b0;
         sync_n <= 1'b1;
      end else if (!busy) begin
         sclk <= 1'b0;
         if (load) begin
            sh_q   <= {word[14:0], 1'b0};
            sdat   <= word[15];
            cnt_q  <= 5'h00;
            busy   <= 1'b1;
            sync_n <= 1'b0;
         end
      end else if (tick) begin
         sclk <= ~sclk;
         if (sclk) begin
            if (cnt_q == `PNLIO_DAC_BITS - 5'h01) begin
               busy   <= 1'b0;
               sync_n <= 1'b1;
            end else begin
               sdat  <= sh_q[15];
               sh_q  <= {sh_q[14:0], 1'b0};
            end
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end
endmodule

//--- sim/pnlio_dac_model.sv
// Receiving end of the display DAC serial load
`timescale 1ns/1ns
module pnlio_dac_model (
   // Serial lines
   input wire        sclk,
   input wire        sdat,
   input wire        sync_n,
   // Captured load
   output reg [15:0] word,
   output reg [15:0] bits
);
   initial begin
      word = 16'h0000;
      bits = 16'h0000;
   end
   // Frame start clears the count, rising clock shifts in MSB first
   always @(posedge sclk or negedge sync_n) begin
      if (!sclk) begin
         bits <= 16'h0000;
      end else if (!sync_n) begin
         word <= {word[14:0], sdat};
         bits <= bits + 16'h0001;
      end
   end
endmodule

//--- sim/pnlio_regs_assertions.sv
// Port checker for the panel I/O register bank
`timescale 1ns/1ns
module pnlio_regs_chk #(
   parameter KEY_W    = 16,
   parameter REV_CODE = 16'h0101
) (
   // Clock, reset and bus
   input wire             MCLK,
   input wire             RESETN,
   input wire             CS,
   input wire             WR,
   input wire             RD,
   input wire [2:0]       ADDR,
   input wire [15:0]      WDATA,
   input wire [15:0]      RDATA,
   // Block pins
   input wire [KEY_W-1:0] KEYS,
   input wire             SPEAKER,
   input wire [15:0]      CTRL_OUT,
   input wire             SHARED_AUDIO_SERIAL_BUS_SCLK,
   input wire             SHARED_AUDIO_SERIAL_BUS_SYNC_N
);
   // Decoded bus cycles
   wire rd_hit = CS && RD;
   wire wr_hit = CS && WR;
   // Cycles since a tone start write while the speaker has not yet risen
   reg        tone_wait_q;
   reg [10:0] tone_cnt_q;
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         tone_wait_q <= 1'b0;
         tone_cnt_q  <= 11'h000;
      end else if (wr_hit && ADDR == 3'h3 && WDATA != 16'h0000) begin
         tone_wait_q <= 1'b1;
         tone_cnt_q  <= 11'h000;
      end else if (SPEAKER || !tone_wait_q || (wr_hit && ADDR == 3'h3)) begin
         tone_wait_q <= 1'b0;
         tone_cnt_q  <= 11'h000;
      end else begin
         tone_cnt_q  <= tone_cnt_q + 11'h001;
      end
   end
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);
   rev_read_a:
      assert property (rd_hit && ADDR == 3'h0 |=> RDATA == REV_CODE)
         else $error("revision read wrong");
   wo_read_a:
      assert property (rd_hit && ADDR == 3'h2 |=> RDATA == 16'h0000)
         else $error("control read not zero");
   ctrl_write_a:
      assert property (wr_hit && ADDR == 3'h2 |=> CTRL_OUT == $past(WDATA))
         else $error("control write lost");
   key_read_a:
      assert property (rd_hit && ADDR == 3'h4 && KEYS == $past(KEYS, 3)
         |=> RDATA[KEY_W-1:0] == $past(KEYS)) else $error("keypad read wrong");
   tone_start_a:
      assert property (tone_wait_q |-> tone_cnt_q < 11'h514)
         else $error("tone did not start");
   tone_stop_a:
      assert property (wr_hit && ADDR == 3'h3 && WDATA == 16'h0000
         |-> ##3 !SPEAKER [*8]) else $error("tone did not stop");
   dac_frame_a:
      assert property (wr_hit && ADDR == 3'h5
         |-> ##[1:4] !SHARED_AUDIO_SERIAL_BUS_SYNC_N) else $error("no frame");
   sclk_idle_a:
      assert property (SHARED_AUDIO_SERIAL_BUS_SYNC_N
         |-> !SHARED_AUDIO_SERIAL_BUS_SCLK) else $error("clock outside frame");
endmodule
bind pnlio_regs pnlio_regs_chk #(.KEY_W(KEY_W), .REV_CODE(REV_CODE)) chk_i (
   .MCLK(MCLK), .RESETN(RESETN), .CS(CS), .WR(WR), .RD(RD), .ADDR(ADDR),
   .WDATA(WDATA), .RDATA(RDATA), .KEYS(KEYS), .SPEAKER(SPEAKER),
   .CTRL_OUT(CTRL_OUT),
   .SHARED_AUDIO_SERIAL_BUS_SCLK(SHARED_AUDIO_SERIAL_BUS_SCLK),
   .SHARED_AUDIO_SERIAL_BUS_SYNC_N(SHARED_AUDIO_SERIAL_BUS_SYNC_N));

//--- sim/tb_pnlio_regs.sv
// Self-checking bench for the panel I/O register bank
`timescale 1ns/1ns
`include "pnlio_defs.vh"
module tb_pnlio_regs;
   reg         MCLK, RESETN, CS, WR, RD;
   reg  [2:0]  ADDR;
   reg  [15:0] WDATA, KEYS, d;
   wire [15:0] RDATA, CTRL_OUT, dac_word, dac_bits;
   wire        SPEAKER, sclk, sdat, sync_n;
   integer     miscompares, n_tests, n;
   pnlio_regs pnlio_regs_i (.MCLK(MCLK), .RESETN(RESETN), .CS(CS), .WR(WR),
      .RD(RD), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .KEYS(KEYS),
      .SPEAKER(SPEAKER), .CTRL_OUT(CTRL_OUT),
      .SHARED_AUDIO_SERIAL_BUS_SCLK(sclk), .SHARED_AUDIO_SERIAL_BUS_SDAT(sdat),
      .SHARED_AUDIO_SERIAL_BUS_SYNC_N(sync_n));
   pnlio_dac_model pnlio_dac_model_i (.sclk(sclk), .sdat(sdat),
      .sync_n(sync_n), .word(dac_word), .bits(dac_bits));
   // Bus cycles and comparison
   task tick;
      @(posedge MCLK) #1;
   endtask
   task wr(input [2:0] a, input [15:0] v);
      begin
         tick;
         CS = 1'h1;
         WR = 1'h1;
         ADDR = a;
         WDATA = v;
         tick;
         CS = 1'h0;
         WR = 1'h0;
      end
   endtask
   task rd(input [2:0] a);
      begin
         tick;
         CS = 1'h1;
         RD = 1'h1;
         ADDR = a;
         tick;
         CS = 1'h0;
         RD = 1'h0;
         d = RDATA;
      end
   endtask
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            miscompares = miscompares + 1;
         end
      end
   endtask
   task final_report;
      begin
         if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Clock
   initial begin
      MCLK = 1'h0;
      forever #50 MCLK = ~MCLK;
   end
   // Watchdog
   initial begin
      #8000000;
      miscompares = miscompares + 1;
      final_report;
   end
   // Test sequence
   initial begin
      {RESETN, CS, WR, RD, ADDR, WDATA, KEYS} = 0;
      miscompares = 0;
      n_tests = 0;
      repeat (2) @(posedge MCLK);
      #1 RESETN = 1'h1;
      wr(`PNLIO_OFS_REV, 16'hffff);
      wr(`PNLIO_OFS_STAT, 16'hffff);
      rd(`PNLIO_OFS_REV);
      chk("rev", `PNLIO_REV_VAL, d);
      rd(`PNLIO_OFS_STAT);
      chk("stat", 16'h0000, d);
      wr(`PNLIO_OFS_CTRL, 16'ha5c3);
      chk("ctrl out", 16'ha5c3, CTRL_OUT);
      rd(`PNLIO_OFS_CTRL);
      chk("ctrl rd", 16'h0000, d);
      KEYS = 16'h0012 | 16'h0140;
      rd(`PNLIO_OFS_KEYS);
      rd(`PNLIO_OFS_KEYS);
      chk("keys", 16'h0152, d);
      wr(`PNLIO_OFS_DAC, 16'hb7e1);
      rd(`PNLIO_OFS_STAT);
      chk("dac busy", 16'h0004, d);
      repeat (200) tick;
      chk("dac word", 16'hb7e1, dac_word);
      chk("dac bits", 16'h0010, dac_bits);
      // A second word written while the shifter is busy is sent next
      wr(`PNLIO_OFS_DAC, 16'h1c35);
      wr(`PNLIO_OFS_DAC, 16'h6a0f);
      repeat (400) tick;
      chk("dac queued", 16'h6a0f, dac_word);
      chk("dac queued bits", 16'h0010, dac_bits);
      // Continuous tone: one high half period, then still on past 1 ms
      wr(`PNLIO_OFS_TONE, 16'h8001);
      n = 0;
      while (!SPEAKER && n < 2000) begin
         tick;
         n = n + 1;
      end
      n = 0;
      while (SPEAKER && n < 2000) begin
         tick;
         n = n + 1;
      end
      chk("half period", 16'h04e2, n[15:0]);
      repeat (15000) tick;
      rd(`PNLIO_OFS_STAT);
      chk("continuous", 16'h0003, d);
      wr(`PNLIO_OFS_TONE, 16'h0000);
      repeat (4) tick;
      chk("silenced", 16'h0000, {15'h0, SPEAKER});
      // Longer value mid-tone extends, then times out
      wr(`PNLIO_OFS_TONE, 16'h0001);
      repeat (3000) tick;
      wr(`PNLIO_OFS_TONE, 16'h0002);
      repeat (12000) tick;
      rd(`PNLIO_OFS_STAT);
      chk("extended", 16'h0001, d);
      repeat (9000) tick;
      rd(`PNLIO_OFS_STAT);
      chk("timed out", 16'h0000, d);
      // Shorter value mid-tone ends it early
      wr(`PNLIO_OFS_TONE, 16'h0002);
      repeat (2000) tick;
      wr(`PNLIO_OFS_TONE, 16'h0001);
      repeat (10500) tick;
      rd(`PNLIO_OFS_STAT);
      chk("shortened", 16'h0000, d);
      chk("speaker", 16'h0000, {15'h0, SPEAKER});
      final_report;
   end
endmodule
